// ---- design/mbag_pkg.sv ----
// Shared constants and types for the modulo and bit-reversed address generator.
package mbag_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] OFS_MODE_CTRL = 12'h000;
   localparam logic [11:0] OFS_BITREV_CTRL = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;

   // Fields of address_mode_control.
   localparam int X_SEL_LSB = 0;
   localparam int Y_SEL_LSB = 4;
   localparam int B_SEL_LSB = 8;
   localparam int SEL_W = 4;
   localparam int Y_EN_BIT = 14;
   localparam int X_EN_BIT = 15;

   // Fields of bit_reverse_control.
   localparam int PIVOT_W = 15;
   localparam int BITREV_EN_BIT = 15;

   // Fields of the status register.
   localparam int ST_X_CIRC = 0;
   localparam int ST_Y_CIRC = 1;
   localparam int ST_BITREV = 2;
   localparam int ST_LAST_BR = 3;

   // A select of all ones names the stack pointer and disables the feature.
   localparam logic [3:0] SEL_NONE = 4'hf;

   // Reset values: every pointer select off, every enable clear.
   localparam logic [15:0] MODE_CTRL_RST = 16'h0fff;
   localparam logic [15:0] BITREV_CTRL_RST = 16'h0000;

   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      MODE_INDIRECT = 3'h0,
      MODE_POST_INC = 3'h1,
      MODE_POST_DEC = 3'h2,
      MODE_PRE_INC = 3'h3,
      MODE_PRE_DEC = 3'h4,
      MODE_OFFSET = 3'h5
   } mbag_mode_t;

endpackage

// ---- design/mbag_circ_corr.sv ----
// Circular buffer boundary correction for one address generator.
`timescale 1ns/10ps
module mbag_circ_corr #(
   parameter int AW = 16,
   parameter bit WORD_ONLY = 1'b0
) (
   input wire logic enable,
   input wire logic dir_up,
   input wire logic [AW-1:0] buf_start,
   input wire logic [AW-1:0] buf_end,
   input wire logic [AW-1:0] addr_in,
   output logic [AW-1:0] addr_out
);

   logic [AW-1:0] len;
   logic [AW-1:0] fixed;

   always_comb begin
      // Length is implied by the bounds, so no separate size register exists.
      len = AW'(buf_end - buf_start + AW'(1));
      fixed = addr_in;
      // Overshoot past a bound is caught by magnitude compare, not equality.
      if (enable && dir_up && addr_in > buf_end) begin
         fixed = AW'(addr_in - len);
      end else if (enable && !dir_up && addr_in < buf_start) begin
         fixed = AW'(addr_in + len);
      end
      addr_out = fixed;
      if (WORD_ONLY) begin
         addr_out[0] = 1'b0;
      end
   end

endmodule // mbag_circ_corr

// ---- design/mbag_revcarry_add.sv ----
// Reverse-carry adder used for bit-reversed pointer updates.
`timescale 1ns/10ps
module mbag_revcarry_add #(
   parameter int W = 16
) (
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   output logic [W-1:0] sum
);

   logic [W-1:0] ra;
   logic [W-1:0] rb;
   logic [W-1:0] rs;

   // Carries run from the top bit downward by adding the mirrored operands.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         ra[i] = a[W-1-i];
         rb[i] = b[W-1-i];
      end
      rs = W'(ra + rb);
      for (int i = 0; i < W; i++) begin
         sum[i] = rs[W-1-i];
      end
   end

endmodule // mbag_revcarry_add

// ---- design/mbag_top.sv ----
// APB-configured modulo and bit-reversed effective address post-processor.
`timescale 1ns/10ps

// Functional notes
// (R1) X circular on: select not 15, enable set.
// (R2) Y circular on: select not 15, enable set.
// (R3) Bounds compared by magnitude; overshoot still wraps.
// (R4) Write back only for pre/post modify.
// (R5) Bit reversal only in X write generator.
// (R6) Only modifier reversed; pointer stays normal order.
// (R7) Bit reversal: select not 15, enable, increment.
// (R8) Control holds enable at top, 15-bit pivot.
// (R9) Software loads pivot with half buffer words.
// (R10) Bit-reversed addresses word aligned, pivot doubled.
// (R11) Byte or other modes give linear address.
// (R12) Bit reversal adds pivot, ignores mode offset.
// (R13) Bit reversal beats circular on X writes.
// (R14) Software avoids pointer read right after update.
// (R15) Bit-reversed buffer start aligned to its size.
// (R16) Y circular addresses keep bit zero clear.
// (R17) Buffer length implied by start/end bounds.
// (R18) Reverse carry runs from top bit down.
module mbag_top #(
   parameter int AW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [AW-1:0] x_buffer_start,
   input wire logic [AW-1:0] x_buffer_end,
   input wire logic [AW-1:0] y_buffer_start,
   input wire logic [AW-1:0] y_buffer_end,
   input wire logic xr_req,
   input wire logic [3:0] xr_reg_sel,
   input wire logic [AW-1:0] xr_ptr,
   input wire logic [AW-1:0] xr_mod,
   input wire mbag_pkg::mbag_mode_t xr_mode,
   output logic xr_valid,
   output logic [AW-1:0] xr_ea,
   output logic xr_wb_en,
   output logic [AW-1:0] xr_wb,
   input wire logic xw_req,
   input wire logic [3:0] xw_reg_sel,
   input wire logic [AW-1:0] xw_ptr,
   input wire logic [AW-1:0] xw_mod,
   input wire mbag_pkg::mbag_mode_t xw_mode,
   input wire logic xw_byte,
   output logic xw_valid,
   output logic [AW-1:0] xw_ea,
   output logic xw_wb_en,
   output logic [AW-1:0] xw_wb,
   input wire logic y_req,
   input wire logic [3:0] y_reg_sel,
   input wire logic [AW-1:0] y_ptr,
   input wire logic [AW-1:0] y_mod,
   input wire mbag_pkg::mbag_mode_t y_mode,
   output logic y_valid,
   output logic [AW-1:0] y_ea,
   output logic y_wb_en,
   output logic [AW-1:0] y_wb
);

   logic [15:0] mode_ctrl_q;
   logic [15:0] bitrev_ctrl_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic last_br_q;
   logic [3:0] x_sel;
   logic [3:0] y_sel;
   logic [3:0] b_sel;
   logic x_circ_on;
   logic y_circ_on;
   logic br_on;
   logic [AW-1:0] pivot_bytes;
   logic setup;
   logic access_done;
   logic [31:0] rd_mux;
   logic rd_err;

   // Configuration decode.
   always_comb begin
      x_sel = mode_ctrl_q[mbag_pkg::X_SEL_LSB +: mbag_pkg::SEL_W];
      y_sel = mode_ctrl_q[mbag_pkg::Y_SEL_LSB +: mbag_pkg::SEL_W];
      b_sel = mode_ctrl_q[mbag_pkg::B_SEL_LSB +: mbag_pkg::SEL_W];
      // (R1) X circular enable
      x_circ_on = mode_ctrl_q[mbag_pkg::X_EN_BIT] && x_sel != mbag_pkg::SEL_NONE;
      // (R2) Y circular enable
      y_circ_on = mode_ctrl_q[mbag_pkg::Y_EN_BIT] && y_sel != mbag_pkg::SEL_NONE;
      // (R7) bit reversal enable
      br_on = bitrev_ctrl_q[mbag_pkg::BITREV_EN_BIT] && b_sel != mbag_pkg::SEL_NONE;
      // (R10) pivot scaled to bytes
      pivot_bytes = AW'({bitrev_ctrl_q[mbag_pkg::PIVOT_W-1:0], 1'b0});
   end

   // APB decode. The slave answers one cycle into the access phase.
   always_comb begin
      setup = psel && !penable;
      access_done = psel && penable && pready_q;
      rd_err = 1'b0;
      rd_mux = mbag_pkg::RD_ZERO;
      unique case (paddr)
         mbag_pkg::OFS_MODE_CTRL: begin
            rd_mux = {16'h0000, mode_ctrl_q};
         end
         mbag_pkg::OFS_BITREV_CTRL: begin
            rd_mux = {16'h0000, bitrev_ctrl_q};
         end
         mbag_pkg::OFS_STATUS: begin
            rd_mux[mbag_pkg::ST_X_CIRC] = x_circ_on;
            rd_mux[mbag_pkg::ST_Y_CIRC] = y_circ_on;
            rd_mux[mbag_pkg::ST_BITREV] = br_on;
            rd_mux[mbag_pkg::ST_LAST_BR] = last_br_q;
            // Status is read-only; a write to it is refused.
            rd_err = pwrite;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= mbag_pkg::RD_ZERO;
      end else if (setup) begin
         pready_q <= 1'b1;
         pslverr_q <= rd_err;
         prdata_q <= pwrite ? mbag_pkg::RD_ZERO : rd_mux;
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // Register writes land at the completing edge only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ctrl_q <= mbag_pkg::MODE_CTRL_RST;
         bitrev_ctrl_q <= mbag_pkg::BITREV_CTRL_RST;
      end else if (access_done && pwrite && !pslverr_q) begin
         if (paddr == mbag_pkg::OFS_MODE_CTRL) begin
            mode_ctrl_q <= pwdata[15:0];
         end
         // (R8) enable and pivot stored
         if (paddr == mbag_pkg::OFS_BITREV_CTRL) begin
            bitrev_ctrl_q <= pwdata[15:0];
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // X read generator: circular correction only.
   logic [AW-1:0] xr_sum;
   logic [AW-1:0] xr_fix;
   logic xr_hit;
   logic xr_modify;

   always_comb begin
      xr_sum = AW'(xr_ptr + xr_mod);
      xr_modify = xr_mode != mbag_pkg::MODE_INDIRECT;
      // (R13) read side keeps circular
      xr_hit = x_circ_on && xr_reg_sel == x_sel && xr_modify;
   end

   // (R3) magnitude bound check
   mbag_circ_corr #(.AW(AW), .WORD_ONLY(1'b0)) u_xr_circ (
      .enable(xr_hit),
      .dir_up(!xr_mod[AW-1]),
      .buf_start(x_buffer_start),
      .buf_end(x_buffer_end),
      .addr_in(xr_sum),
      .addr_out(xr_fix)
   );

   logic xr_valid_q;
   logic [AW-1:0] xr_ea_q;
   logic xr_wb_en_q;
   logic [AW-1:0] xr_wb_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xr_valid_q <= 1'b0;
         xr_ea_q <= '0;
         xr_wb_en_q <= 1'b0;
         xr_wb_q <= '0;
      end else begin
         xr_valid_q <= xr_req;
         if (xr_req) begin
            xr_ea_q <= xr_fix;
            if (xr_mode == mbag_pkg::MODE_INDIRECT || xr_mode == mbag_pkg::MODE_POST_INC ||
                xr_mode == mbag_pkg::MODE_POST_DEC) begin
               xr_ea_q <= xr_ptr;
            end
            // (R4) write back only when modifying
            xr_wb_en_q <= xr_modify && xr_mode != mbag_pkg::MODE_OFFSET;
            xr_wb_q <= xr_fix;
         end else begin
            xr_wb_en_q <= 1'b0;
         end
      end
   end

   assign xr_valid = xr_valid_q;
   assign xr_ea = xr_ea_q;
   assign xr_wb_en = xr_wb_en_q;
   assign xr_wb = xr_wb_q;

   // X write generator: bit reversal, or circular correction when bit reversal does not apply.
   logic [AW-1:0] xw_sum;
   logic [AW-1:0] xw_fix;
   logic [AW-1:0] xw_br;
   logic [AW-2:0] xw_br_word;
   logic [AW-1:0] xw_base;
   logic xw_inc;
   logic xw_br_hit;
   logic xw_circ_hit;
   logic xw_modify;

   always_comb begin
      xw_sum = AW'(xw_ptr + xw_mod);
      xw_modify = xw_mode != mbag_pkg::MODE_INDIRECT;
      xw_inc = xw_mode == mbag_pkg::MODE_PRE_INC || xw_mode == mbag_pkg::MODE_POST_INC;
      // (R5) only writes; (R11) word increment modes only
      xw_br_hit = br_on && xw_reg_sel == b_sel && xw_inc && !xw_byte;
      // (R13) bit reversal suppresses circular
      xw_circ_hit = x_circ_on && xw_reg_sel == x_sel && xw_modify && !xw_br_hit;
      // (R10) word aligned pointer
      xw_base = {xw_ptr[AW-1:1], 1'b0};
   end

   // (R3) magnitude bound check
   mbag_circ_corr #(.AW(AW), .WORD_ONLY(1'b0)) u_xw_circ (
      .enable(xw_circ_hit),
      .dir_up(!xw_mod[AW-1]),
      .buf_start(x_buffer_start),
      .buf_end(x_buffer_end),
      .addr_in(xw_sum),
      .addr_out(xw_fix)
   );

   // (R6) (R12) (R18) pointer plus reversed pivot
   // The adder spans the word index only, so a carry never reaches byte bit zero.
   mbag_revcarry_add #(.W(AW-1)) u_xw_rev (
      .a(xw_base[AW-1:1]),
      .b(pivot_bytes[AW-1:1]),
      .sum(xw_br_word)
   );

   // (R10) reversed address word aligned
   assign xw_br = {xw_br_word, 1'b0};

   logic xw_valid_q;
   logic [AW-1:0] xw_ea_q;
   logic xw_wb_en_q;
   logic [AW-1:0] xw_wb_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xw_valid_q <= 1'b0;
         xw_ea_q <= '0;
         xw_wb_en_q <= 1'b0;
         xw_wb_q <= '0;
         last_br_q <= 1'b0;
      end else begin
         xw_valid_q <= xw_req;
         if (xw_req && xw_br_hit) begin
            // (R12) pivot replaces the offset
            xw_ea_q <= (xw_mode == mbag_pkg::MODE_PRE_INC) ? xw_br : xw_base;
            xw_wb_en_q <= 1'b1;
            xw_wb_q <= xw_br;
            last_br_q <= 1'b1;
         end else if (xw_req) begin
            // (R11) linear address otherwise
            xw_ea_q <= xw_fix;
            if (xw_mode == mbag_pkg::MODE_INDIRECT || xw_mode == mbag_pkg::MODE_POST_INC ||
                xw_mode == mbag_pkg::MODE_POST_DEC) begin
               xw_ea_q <= xw_ptr;
            end
            // (R4) write back only when modifying
            xw_wb_en_q <= xw_modify && xw_mode != mbag_pkg::MODE_OFFSET;
            xw_wb_q <= xw_fix;
            last_br_q <= 1'b0;
         end else begin
            xw_wb_en_q <= 1'b0;
         end
      end
   end

   assign xw_valid = xw_valid_q;
   assign xw_ea = xw_ea_q;
   assign xw_wb_en = xw_wb_en_q;
   assign xw_wb = xw_wb_q;

   // Y generator: circular correction on word data.
   logic [AW-1:0] y_sum;
   logic [AW-1:0] y_fix;
   logic y_hit;
   logic y_modify;

   always_comb begin
      y_sum = AW'(y_ptr + y_mod);
      y_modify = y_mode != mbag_pkg::MODE_INDIRECT;
      y_hit = y_circ_on && y_reg_sel == y_sel && y_modify;
   end

   // (R3) (R16) (R17) word-only Y correction
   mbag_circ_corr #(.AW(AW), .WORD_ONLY(1'b1)) u_y_circ (
      .enable(y_hit),
      .dir_up(!y_mod[AW-1]),
      .buf_start(y_buffer_start),
      .buf_end(y_buffer_end),
      .addr_in(y_sum),
      .addr_out(y_fix)
   );

   logic y_valid_q;
   logic [AW-1:0] y_ea_q;
   logic y_wb_en_q;
   logic [AW-1:0] y_wb_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         y_valid_q <= 1'b0;
         y_ea_q <= '0;
         y_wb_en_q <= 1'b0;
         y_wb_q <= '0;
      end else begin
         y_valid_q <= y_req;
         if (y_req) begin
            y_ea_q <= y_fix;
            if (y_mode == mbag_pkg::MODE_INDIRECT || y_mode == mbag_pkg::MODE_POST_INC ||
                y_mode == mbag_pkg::MODE_POST_DEC) begin
               // (R16) word address from pointer
               y_ea_q <= y_hit ? {y_ptr[AW-1:1], 1'b0} : y_ptr;
            end
            // (R4) write back only when modifying
            y_wb_en_q <= y_modify && y_mode != mbag_pkg::MODE_OFFSET;
            y_wb_q <= y_fix;
         end else begin
            y_wb_en_q <= 1'b0;
         end
      end
   end

   assign y_valid = y_valid_q;
   assign y_ea = y_ea_q;
   assign y_wb_en = y_wb_en_q;
   assign y_wb = y_wb_q;

endmodule // mbag_top

// ---- verification/mbag_top_asserts.sv ----
// Port-level assertions for the address generator top.
`timescale 1ns/10ps
module mbag_top_asserts #(
   parameter int AW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic xr_req,
   input wire logic [AW-1:0] xr_ptr,
   input wire logic [AW-1:0] xr_mod,
   input wire mbag_pkg::mbag_mode_t xr_mode,
   input wire logic xr_valid,
   input wire logic [AW-1:0] xr_ea,
   input wire logic xr_wb_en,
   input wire logic [AW-1:0] xr_wb,
   input wire logic xw_req,
   input wire logic [3:0] xw_reg_sel,
   input wire logic [AW-1:0] xw_ptr,
   input wire logic [AW-1:0] xw_mod,
   input wire mbag_pkg::mbag_mode_t xw_mode,
   input wire logic xw_byte,
   input wire logic xw_valid,
   input wire logic [AW-1:0] xw_ea,
   input wire logic xw_wb_en,
   input wire logic [AW-1:0] xw_wb,
   input wire logic y_req,
   input wire logic [3:0] y_reg_sel,
   input wire mbag_pkg::mbag_mode_t y_mode,
   input wire logic [AW-1:0] y_wb
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] mc_q;
   logic [15:0] br_q;
   // Shadow copies let the checker know which corrections are armed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_q <= mbag_pkg::MODE_CTRL_RST;
         br_q <= mbag_pkg::BITREV_CTRL_RST;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == mbag_pkg::OFS_MODE_CTRL) mc_q <= pwdata[15:0];
         if (paddr == mbag_pkg::OFS_BITREV_CTRL) br_q <= pwdata[15:0];
      end
   end
   sequence s_rev;
      xw_req && br_q[15] && mc_q[11:8] != 4'hf && xw_reg_sel == mc_q[11:8] && !xw_byte
         && (xw_mode == mbag_pkg::MODE_PRE_INC || xw_mode == mbag_pkg::MODE_POST_INC);
   endsequence
   a_xr_valid_next: assert property (xr_req |=> xr_valid)
      else $error("xr valid missing");
   a_xw_valid_quiet: assert property (!xw_req |=> !xw_valid)
      else $error("xw valid without request");
   a_offset_no_wb: assert property (
      xr_req && xr_mode == mbag_pkg::MODE_OFFSET |=> !xr_wb_en) else $error("offset wrote back");
   a_modify_wb_on: assert property (
      xw_req && xw_mode != mbag_pkg::MODE_INDIRECT && xw_mode != mbag_pkg::MODE_OFFSET
      |=> xw_wb_en) else $error("modify without write back");
   a_xr_read_linear: assert property (
      xr_req && !mc_q[15] && xr_mode == mbag_pkg::MODE_POST_INC
      |=> xr_ea == $past(xr_ptr) && xr_wb == $past(xr_ptr) + $past(xr_mod))
      else $error("read not linear");
   a_rev_word_even: assert property (
      s_rev |=> xw_wb_en && !xw_ea[0] && !xw_wb[0]) else $error("reversed address odd");
   a_byte_linear: assert property (
      xw_req && xw_byte && !mc_q[15] && xw_mode == mbag_pkg::MODE_POST_INC
      |=> xw_wb == $past(xw_ptr) + $past(xw_mod)) else $error("byte write not linear");
   a_y_word_even: assert property (
      y_req && mc_q[14] && mc_q[7:4] != 4'hf && y_reg_sel == mc_q[7:4]
      && y_mode != mbag_pkg::MODE_INDIRECT |=> !y_wb[0]) else $error("y address odd");
endmodule // mbag_top_asserts

// ---- verification/mbag_cpu_model.sv ----
// Decoder model that issues effective-address requests.
`timescale 1ns/10ps
module mbag_cpu_model (
   input wire logic pclk,
   output logic [2:0] req,
   output logic [3:0] sel,
   output logic [15:0] ptr,
   output logic [15:0] mod,
   output mbag_pkg::mbag_mode_t mode,
   output logic byte_acc
);
   initial begin
      req = 3'h0;
      sel = 4'hf;
      ptr = 16'h0000;
      mod = 16'h0000;
      mode = mbag_pkg::MODE_INDIRECT;
      byte_acc = 1'b0;
   end
   task automatic issue(input int g, input logic [3:0] s, input logic [15:0] p, m,
         input mbag_pkg::mbag_mode_t md, input logic b);
      @(posedge pclk);
      req[g] <= 1'b1;
      sel <= s;
      ptr <= p;
      mod <= m;
      mode <= md;
      byte_acc <= b;
      @(posedge pclk);
      req <= 3'h0;
      // Released pointer, modifier and select never keep the last value; mode and byte flag do.
      ptr <= ~p;
      mod <= ~m;
      sel <= ~s;
   endtask
endmodule // mbag_cpu_model

// ---- verification/mbag_top_bench.sv ----
// Self-checking bench for the address generator top.
`timescale 1ns/10ps
module mbag_top_bench;
   localparam logic [11:0] MC = mbag_pkg::OFS_MODE_CTRL;
   localparam logic [11:0] BC = mbag_pkg::OFS_BITREV_CTRL;
   localparam mbag_pkg::mbag_mode_t IND = mbag_pkg::MODE_INDIRECT;
   localparam mbag_pkg::mbag_mode_t POI = mbag_pkg::MODE_POST_INC;
   localparam mbag_pkg::mbag_mode_t POD = mbag_pkg::MODE_POST_DEC;
   localparam mbag_pkg::mbag_mode_t PRI = mbag_pkg::MODE_PRE_INC;
   localparam mbag_pkg::mbag_mode_t PRD = mbag_pkg::MODE_PRE_DEC;
   localparam mbag_pkg::mbag_mode_t OFS = mbag_pkg::MODE_OFFSET;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, byte_acc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] x_buffer_start, x_buffer_end, y_buffer_start, y_buffer_end, ptr, mod;
   logic [2:0] req;
   logic [3:0] sel;
   mbag_pkg::mbag_mode_t mode;
   logic xr_valid, xr_wb_en, xw_valid, xw_wb_en, y_valid, y_wb_en;
   logic [15:0] xr_ea, xr_wb, xw_ea, xw_wb, y_ea, y_wb;
   logic [2:0][15:0] ea_v, wb_v;
   int err_count = 0;
   int check_count = 0;
   assign ea_v = {y_ea, xw_ea, xr_ea};
   assign wb_v = {y_wb, xw_wb, xr_wb};
   mbag_cpu_model cpu (.pclk(pclk), .req(req), .sel(sel), .ptr(ptr), .mod(mod), .mode(mode),
      .byte_acc(byte_acc));
   mbag_top #(.AW(16)) dut (.*, .xr_req(req[0]), .xw_req(req[1]), .y_req(req[2]),
      .xr_reg_sel(sel), .xw_reg_sel(sel), .y_reg_sel(sel), .xr_ptr(ptr), .xw_ptr(ptr),
      .y_ptr(ptr), .xr_mod(mod), .xw_mod(mod), .y_mod(mod), .xr_mode(mode),
      .xw_mode(mode), .y_mode(mode), .xw_byte(byte_acc));
   always #20 pclk = ~pclk;
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, exp,
         input logic ee);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer is taken at the edge that samples pready high; only the watchdog ends a hang.
      do @(posedge pclk); while (pready !== 1'b1);
      if (!w) chk("prdata", prdata, exp);
      chk("pslverr", {31'h0, pslverr}, {31'h0, ee});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic gen(input int g, input logic [3:0] s, input logic [15:0] p, m,
         input mbag_pkg::mbag_mode_t md, input logic b, input logic [15:0] ea, wb,
         input logic we);
      cpu.issue(g, s, p, m, md, b);
      @(posedge pclk);
      chk("valid", {29'h0, y_valid, xw_valid, xr_valid}, 32'h1 << g);
      chk("ea", {16'h0, ea_v[g]}, {16'h0, ea});
      chk("wb_en", {31'h0, g == 0 ? xr_wb_en : g == 1 ? xw_wb_en : y_wb_en}, {31'h0, we});
      if (we) chk("wb", {16'h0, wb_v[g]}, {16'h0, wb});
   endtask
   function automatic logic [15:0] brv(input int k);
      return 16'h0800 + {11'h0, k[0], k[1], k[2], k[3], 1'b0};
   endfunction
   initial begin
      #120000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      int k;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      x_buffer_start = 16'h1000;
      x_buffer_end = 16'h101f;
      y_buffer_start = 16'h2000;
      y_buffer_end = 16'h203f;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, MC, 32'h0, 32'h0000_0fff, 0);
      apb(0, BC, 32'h0, 32'h0, 0);
      apb(0, 12'h00c, 32'h0, 32'h0, 1);
      apb(1, MC, 32'h0000_8ff2, 32'h0, 0);
      gen(0, 4'h2, 16'h101e, 16'h0004, POI, 0, 16'h101e, 16'h1002, 1);
      gen(0, 4'h2, 16'h101e, 16'h0006, OFS, 0, 16'h1004, 16'h0, 0);
      gen(1, 4'h2, 16'h1000, 16'hfffe, PRD, 0, 16'h101e, 16'h101e, 1);
      gen(0, 4'h3, 16'h101e, 16'h0004, POI, 0, 16'h101e, 16'h1022, 1);
      apb(1, MC, 32'h0000_0ff2, 32'h0, 0);
      gen(0, 4'h2, 16'h101e, 16'h0004, POI, 0, 16'h101e, 16'h1022, 1);
      apb(1, MC, 32'h0000_4f5f, 32'h0, 0);
      gen(2, 4'h5, 16'h203e, 16'h0003, PRI, 0, 16'h2000, 16'h2000, 1);
      gen(2, 4'h5, 16'h2010, 16'h0002, IND, 0, 16'h2010, 16'h0, 0);
      x_buffer_start <= 16'h0800;
      x_buffer_end <= 16'h0807;
      apb(1, BC, 32'hffff_8008, 32'h0, 0);
      apb(0, BC, 32'h0, 32'h0000_8008, 0);
      apb(1, MC, 32'h0000_01ff, 32'h0, 0);
      for (k = 0; k < 15; k++) begin
         gen(1, 4'h1, brv(k) | 16'h1, 16'h0000, POI, 0, brv(k), brv(k + 1), 1);
      end
      gen(1, 4'h1, 16'h0800, 16'h0002, PRI, 0, 16'h0810, 16'h0810, 1);
      gen(1, 4'h1, 16'h0800, 16'h0002, POI, 1, 16'h0800, 16'h0802, 1);
      gen(1, 4'h1, 16'h0800, 16'hfffe, POD, 0, 16'h0800, 16'h07fe, 1);
      gen(0, 4'h1, 16'h0800, 16'h0002, POI, 0, 16'h0800, 16'h0802, 1);
      apb(1, MC, 32'h0000_81f1, 32'h0, 0);
      gen(1, 4'h1, 16'h0800, 16'h0002, POI, 0, 16'h0800, 16'h0810, 1);
      gen(0, 4'h1, 16'h0806, 16'h0002, POI, 0, 16'h0806, 16'h0800, 1);
      apb(0, mbag_pkg::OFS_STATUS, 32'h0, 32'h0000_000d, 0);
      apb(1, mbag_pkg::OFS_STATUS, 32'h0000_0000, 32'h0, 1);
      apb(1, BC, 32'h0000_0008, 32'h0, 0);
      gen(1, 4'h1, 16'h0802, 16'h0002, POI, 0, 16'h0802, 16'h0804, 1);
      // A reset in mid-run must bring both control registers back to their defaults.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, MC, 32'h0, 32'h0000_0fff, 0);
      apb(0, BC, 32'h0, 32'h0, 0);
      gen(1, 4'h1, 16'h0802, 16'h0002, PRI, 0, 16'h0804, 16'h0804, 1);
      tally_and_finish();
   end
endmodule // mbag_top_bench
bind mbag_top mbag_top_asserts #(.AW(AW)) u_chk (.*);
